/* common/dac_loader_pkg.sv */
`default_nettype none
package dac_loader_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Word geometry
   localparam int unsigned WORD_BITS  = 16;
   localparam int unsigned CODE_BITS  = 10;
   localparam int unsigned CNT_BITS   = 4;
   localparam logic [3:0]  LAST_BIT   = 4'hf;  // Index of 16th edge

   // Field positions inside the shifted word
   localparam int unsigned SEL_POS    = 15;    // 0 = channel A, 1 = B
   localparam int unsigned OP_HI      = 14;
   localparam int unsigned OP_LO      = 13;
   localparam int unsigned TERM_HI    = 12;
   localparam int unsigned TERM_LO    = 11;
   localparam int unsigned CODE_HI    = 9;
   localparam int unsigned CODE_LO    = 0;

   ////////////////////////////////////////////////////////////////////////
   // Operation codes carried in the mode bits
   localparam logic [1:0] OP_WRITE_UPD  = 2'h0;  // Load and update one
   localparam logic [1:0] OP_WRITE_ONLY = 2'h1;  // Load, no update
   localparam logic [1:0] OP_UPD_BOTH   = 2'h2;  // Load, update both
   localparam logic [1:0] OP_PWR_DOWN   = 2'h3;

   // Power-down state shown on the pd output
   localparam logic [1:0] PD_ACTIVE    = 2'h0;
   localparam logic [1:0] PD_1K_GND    = 2'h1;
   localparam logic [1:0] PD_100K_GND  = 2'h2;
   localparam logic [1:0] PD_HIGH_Z    = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [9:0]  CODE_RST    = 10'h000;
   localparam logic [1:0]  PD_RST      = 2'h0;
   localparam logic [2:0]  PIN_RST     = 3'h1;   // {din, sclk, sel_b}

   ////////////////////////////////////////////////////////////////////////
   // Timing: hold-off after each output update (converter settling)
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned SETTLE_NS     = 6000;
   localparam int unsigned SETTLE_CYC    =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_BITS   = 11;
   localparam int unsigned FIFO_DEPTH    = 4;

endpackage
`default_nettype wire

/* common/word_stream_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Valid/ready word stream between the frame logic, FIFO and applier
interface word_stream_if #(
   parameter int unsigned WIDTH = 16
);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* rtl/dual_dac_serial_loader.sv */
`timescale 1ns/100ps
`default_nettype none
module dual_dac_serial_loader #(
   parameter int unsigned FIFO_DEPTH = dac_loader_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   // Serial pins from the host
   input  wire logic       frame_sel_b_i,
   input  wire logic       sclk_i,
   input  wire logic       sdata_i,
   // Converter channel codes
   output logic [9:0]      channel_a_output_o,
   output logic [9:0]      channel_b_output_o,
   // Power-down state and events
   output logic [1:0]      pd_mode_o,
   output logic            update_o,
   output logic            frame_abort_o,
   output logic            frame_drop_o
);

   ////////////////////////////////////////////////////////////////////////
   // Types and state
   typedef enum logic [2:0] {
      FR_IDLE  = 3'b001,
      FR_SHIFT = 3'b010,
      FR_DONE  = 3'b100
   } frame_e;

   typedef logic [dac_loader_pkg::CODE_BITS-1:0] code_t;
   typedef logic [dac_loader_pkg::WORD_BITS-1:0] word_t;

   typedef struct packed {
      frame_e                                       fr;
      logic                                         sel_prev;
      logic                                         sclk_prev;
      logic [dac_loader_pkg::CNT_BITS-1:0]          cnt;
      word_t                                        shreg;
      logic                                         pend;
      word_t                                        word;
      code_t                                        in_a;
      code_t                                        in_b;
      code_t                                        out_a;
      code_t                                        out_b;
      logic [1:0]                                   pd;
      logic [dac_loader_pkg::SETTLE_BITS-1:0]       settle;
      logic                                         upd;
      logic                                         abort;
      logic                                         drop;
   } top_s;

   top_s  st_q;
   top_s  st_d;
   logic  [2:0] pins;
   logic  sel_b;
   logic  sclk;
   logic  sdata;
   logic  sel_fall;
   logic  sclk_fall;
   word_t aw;
   code_t code;

   word_stream_if #(.WIDTH(dac_loader_pkg::WORD_BITS)) fill_s ();
   word_stream_if #(.WIDTH(dac_loader_pkg::WORD_BITS)) drain_s ();

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the link clock is sampled like any other pin.
   // Sampling at 200 MHz limits the usable shift clock to about 1/8 of
   // that, well below the 40 MHz the pins could otherwise carry.
   pin_sync #(
      .WIDTH   (3),
      .RST_VAL (dac_loader_pkg::PIN_RST)
   ) u_sync (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .pin_i   ({sdata_i, sclk_i, frame_sel_b_i}),
      .level_o (pins)
   );

   // Data and clock pass the same stages, so they stay aligned
   assign sel_b     = pins[0];
   assign sclk      = pins[1];
   assign sdata     = pins[2];
   assign sel_fall  = st_q.sel_prev & ~sel_b;
   assign sclk_fall = st_q.sclk_prev & ~sclk;

   ////////////////////////////////////////////////////////////////////////
   // Word buffer between frame capture and the applier
   word_fifo #(
      .WIDTH   (dac_loader_pkg::WORD_BITS),
      .DEPTH   (FIFO_DEPTH)
   ) u_fifo (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .wr      (fill_s.snk),
      .rd      (drain_s.src)
   );

   // Pending word is offered until the FIFO takes it
   assign fill_s.valid  = st_q.pend;
   assign fill_s.data   = st_q.word;
   // Applier stalls while the last update is still settling
   assign drain_s.ready = (st_q.settle == '0);

   assign aw   = drain_s.data;
   assign code = aw[dac_loader_pkg::CODE_HI:dac_loader_pkg::CODE_LO];

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      st_d           = st_q;
      st_d.sel_prev  = sel_b;
      st_d.sclk_prev = sclk;
      st_d.upd       = 1'b0;
      st_d.abort     = 1'b0;
      st_d.drop      = 1'b0;

      // Handshake into the FIFO clears the pending word
      if (st_q.pend && fill_s.ready) begin
         st_d.pend = 1'b0;
      end

      // Frame capture
      unique case (st_q.fr)
         FR_IDLE: begin
            if (sel_fall) begin
               st_d.fr  = FR_SHIFT;
               st_d.cnt = '0;
            end
         end
         FR_SHIFT: begin
            if (sel_b) begin
               // Partial word is dropped; outputs untouched
               st_d.fr    = FR_IDLE;
               st_d.abort = 1'b1;
            end else if (sclk_fall) begin
               st_d.shreg = {st_q.shreg[dac_loader_pkg::WORD_BITS-2:0],
                             sdata};
               st_d.cnt   = st_q.cnt + 1'b1;
               if (st_q.cnt == dac_loader_pkg::LAST_BIT) begin
                  st_d.fr = FR_DONE;
                  // A word still waiting keeps its place; the new one
                  // is lost and flagged rather than overwriting it
                  if (st_d.pend) begin
                     st_d.drop = 1'b1;
                  end else begin
                     st_d.pend = 1'b1;
                     st_d.word = {st_q.shreg[dac_loader_pkg::WORD_BITS-2:0],
                                  sdata};
                  end
               end
            end
         end
         FR_DONE: begin
            // Extra edges are ignored until select goes high again
            if (sel_b) begin
               st_d.fr = FR_IDLE;
            end
         end
      endcase

      // Settle countdown after an update
      if (st_q.settle != '0) begin
         st_d.settle = st_q.settle - 1'b1;
      end

      // Applier: decode one word per settle window
      if (drain_s.valid && drain_s.ready) begin
         unique case (aw[dac_loader_pkg::OP_HI:dac_loader_pkg::OP_LO])
            dac_loader_pkg::OP_WRITE_UPD: begin
               if (aw[dac_loader_pkg::SEL_POS]) begin
                  st_d.in_b  = code;
                  st_d.out_b = code;
               end else begin
                  st_d.in_a  = code;
                  st_d.out_a = code;
               end
               st_d.pd = dac_loader_pkg::PD_ACTIVE;
            end
            dac_loader_pkg::OP_WRITE_ONLY: begin
               if (aw[dac_loader_pkg::SEL_POS]) begin
                  st_d.in_b = code;
               end else begin
                  st_d.in_a = code;
               end
            end
            dac_loader_pkg::OP_UPD_BOTH: begin
               // Both outputs move in the same cycle
               if (aw[dac_loader_pkg::SEL_POS]) begin
                  st_d.in_b  = code;
                  st_d.out_a = st_q.in_a;
                  st_d.out_b = code;
               end else begin
                  st_d.in_a  = code;
                  st_d.out_a = code;
                  st_d.out_b = st_q.in_b;
               end
               st_d.pd = dac_loader_pkg::PD_ACTIVE;
            end
            dac_loader_pkg::OP_PWR_DOWN: begin
               // Termination field 0 has no meaning; treat as high-Z
               st_d.pd = (aw[dac_loader_pkg::TERM_HI:
                             dac_loader_pkg::TERM_LO] == 2'h0) ?
                         dac_loader_pkg::PD_HIGH_Z :
                         aw[dac_loader_pkg::TERM_HI:
                            dac_loader_pkg::TERM_LO];
            end
         endcase
         st_d.upd    = 1'b1;
         st_d.settle = dac_loader_pkg::SETTLE_BITS'(
                          dac_loader_pkg::SETTLE_CYC);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; outputs come up at zero and stay there until the
   // first complete word is applied
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         st_q           <= '0;
         st_q.fr        <= FR_IDLE;
         st_q.sel_prev  <= 1'b1;
         st_q.out_a     <= dac_loader_pkg::CODE_RST;
         st_q.out_b     <= dac_loader_pkg::CODE_RST;
         st_q.pd        <= dac_loader_pkg::PD_RST;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign channel_a_output_o = st_q.out_a;
   assign channel_b_output_o = st_q.out_b;
   assign pd_mode_o          = st_q.pd;
   assign update_o           = st_q.upd;
   assign frame_abort_o      = st_q.abort;
   assign frame_drop_o       = st_q.drop;

endmodule // dual_dac_serial_loader
`default_nettype wire

/* rtl/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int unsigned        WIDTH   = 3,
   parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             mclk_i,
   input  wire logic             rst_b_i,
   // Raw pins and filtered levels
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] level_o
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } sync_s;

   sync_s st_q;
   sync_s st_d;

   ////////////////////////////////////////////////////////////////////////
   // A bit only moves once stages two and three agree; s1 feeds s2 alone
   always_comb begin
      st_d     = st_q;
      st_d.s1  = pin_i;
      st_d.s2  = st_q.s1;
      st_d.s3  = st_q.s2;
      st_d.lvl = (st_q.s3 & ~(st_q.s2 ^ st_q.s3)) |
                 (st_q.lvl & (st_q.s2 ^ st_q.s3));
   end

   // State register
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         st_q <= {4{RST_VAL}};
      end else begin
         st_q <= st_d;
      end
   end

   assign level_o = st_q.lvl;

endmodule // pin_sync
`default_nettype wire

/* rtl/word_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset
   input  wire logic   mclk_i,
   input  wire logic   rst_b_i,
   // Fill and drain sides
   word_stream_if.snk  wr,
   word_stream_if.src  rd
);

   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [CW-1:0]               cnt;
   } fifo_s;

   fifo_s st_q;
   fifo_s st_d;
   logic  push;
   logic  pop;

   ////////////////////////////////////////////////////////////////////////
   // Pointers wrap at DEPTH so any depth works, not only powers of two
   always_comb begin
      st_d = st_q;
      push = wr.valid && (st_q.cnt != CW'(DEPTH));
      pop  = rd.ready && (st_q.cnt != '0);
      if (push) begin
         st_d.mem[st_q.wp] = wr.data;
         st_d.wp = (st_q.wp == AW'(DEPTH - 1)) ? '0 : AW'(st_q.wp + 1'b1);
      end
      if (pop) begin
         st_d.rp = (st_q.rp == AW'(DEPTH - 1)) ? '0 : AW'(st_q.rp + 1'b1);
      end
      st_d.cnt = CW'(st_q.cnt + CW'(push) - CW'(pop));
   end

   // State register
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Honest full and empty
   assign wr.ready = (st_q.cnt != CW'(DEPTH));
   assign rd.valid = (st_q.cnt != '0);
   assign rd.data  = st_q.mem[st_q.rp];

endmodule // word_fifo
`default_nettype wire

/* verif/dac_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dac_host_model (
   // Serial pins toward the loader
   output var logic frame_sel_b_o,
   output var logic sclk_o,
   output var logic sdata_o
);
   // Idle: select high, shift clock parked high between frames
   initial begin
      frame_sel_b_o = 1'b1;
      sclk_o        = 1'b1;
      sdata_o       = 1'b0;
   end

   // One frame of n falling edges, MSB first; n below 16 aborts it
   task automatic send(input logic [15:0] w, input int n);
      frame_sel_b_o = 1'b0;
      #40;
      for (int i = 0; i < n; i++) begin
         sdata_o = w[15-i];    // Set up well before the fall
         #32 sclk_o = 1'b0;    // 64 ns period stays under 40 MHz
         #32 sclk_o = 1'b1;
      end
      #40 frame_sel_b_o = 1'b1;
      sdata_o = ~sdata_o;       // Released line shows no stale bit
      #40;
   endtask

   // Shift clock toggling while select stays high; nothing may shift
   task automatic stray(input int n);
      for (int i = 0; i < n; i++) begin
         sdata_o = ~sdata_o;
         #32 sclk_o = 1'b0;
         #32 sclk_o = 1'b1;
      end
      #40;
   endtask
endmodule // dac_host_model
`default_nettype wire

/* verif/dac_loader_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module dac_loader_checker #(
   parameter int unsigned FIFO_DEPTH = 4
) (
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   // Serial pins
   input  wire logic       frame_sel_b_i,
   input  wire logic       sclk_i,
   input  wire logic       sdata_i,
   // Outputs watched
   input  wire logic [9:0] channel_a_output_o,
   input  wire logic [9:0] channel_b_output_o,
   input  wire logic [1:0] pd_mode_o,
   input  wire logic       update_o,
   input  wire logic       frame_abort_o,
   input  wire logic       frame_drop_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   ////////////////////////////////////////////////////////////////////
   // Cycles since the last applied word, saturating so reset is safe
   logic [10:0] gap_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i)
         gap_q <= 11'h7ff;
      else if (update_o)
         gap_q <= 11'h000;
      else if (gap_q != 11'h7ff)
         gap_q <= gap_q + 11'h001;
   end

   // Codes and power-down only move with an applied word
   code_cause_a: assert property (
      $changed({channel_a_output_o, channel_b_output_o}) |-> update_o)
      else $error("code changed without update");
   pd_cause_a: assert property ($changed(pd_mode_o) |-> update_o)
      else $error("power-down changed without update");
   abort_sel_a: assert property (
      frame_abort_o |-> $past(frame_sel_b_i, 3))
      else $error("abort without select high");
   abort_pulse_a: assert property (frame_abort_o |=> !frame_abort_o)
      else $error("abort pulse too long");
   drop_pulse_a: assert property (frame_drop_o |=> !frame_drop_o)
      else $error("drop pulse too long");
   rst_zero_a: assert property ($rose(rst_b_i) |->
      channel_a_output_o == 10'h000 && channel_b_output_o == 10'h000
      && pd_mode_o == 2'h0) else $error("outputs not zero after reset");
   rst_quiet_a: assert property ($rose(rst_b_i) |-> !update_o [*8])
      else $error("update right after reset");
   settle_gap_a: assert property (
      update_o |-> gap_q >= 11'(dac_loader_pkg::SETTLE_CYC))
      else $error("update inside settle time");
   pd_codes_a: assert property (
      update_o && pd_mode_o != dac_loader_pkg::PD_ACTIVE
      |-> $stable({channel_a_output_o, channel_b_output_o}))
      else $error("codes moved while powered down");
   code_pd_a: assert property (
      update_o && $changed({channel_a_output_o, channel_b_output_o})
      |-> pd_mode_o == dac_loader_pkg::PD_ACTIVE)
      else $error("code load left power-down set");

   // Main scenarios reached
   cov_pd: cover property (update_o && pd_mode_o != 2'h0);
   cov_abort: cover property (frame_abort_o);
   cov_drop: cover property (frame_drop_o);
   cov_stray: cover property (frame_sel_b_i && $fell(sclk_i));
endmodule // dac_loader_checker

bind dual_dac_serial_loader dac_loader_checker #(.FIFO_DEPTH(FIFO_DEPTH))
   i_dac_loader_checker (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
   .frame_sel_b_i(frame_sel_b_i), .sclk_i(sclk_i), .sdata_i(sdata_i),
   .channel_a_output_o(channel_a_output_o),
   .channel_b_output_o(channel_b_output_o), .pd_mode_o(pd_mode_o),
   .update_o(update_o), .frame_abort_o(frame_abort_o),
   .frame_drop_o(frame_drop_o));
`default_nettype wire

/* verif/dual_dac_serial_loader_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module dual_dac_serial_loader_tb_top;
   logic        mclk = 1'b0;
   logic        rst_b;
   logic        sel_b;
   logic        sclk;
   logic        sdata;
   logic [9:0]  ch_a;
   logic [9:0]  ch_b;
   logic [1:0]  pd;
   logic        upd;
   logic        abrt;
   logic        drop;
   logic [21:0] exp_q[$];
   logic [9:0]  in_a, in_b, out_a, out_b;
   logic [1:0]  pd_m;
   logic [15:0] w;
   int          error_cnt, n_checks, abort_cnt, drop_cnt, seed;

   dual_dac_serial_loader #(.FIFO_DEPTH(dac_loader_pkg::FIFO_DEPTH))
      i_dual_dac_serial_loader (.mclk_i(mclk), .rst_b_i(rst_b),
      .frame_sel_b_i(sel_b), .sclk_i(sclk), .sdata_i(sdata),
      .channel_a_output_o(ch_a), .channel_b_output_o(ch_b),
      .pd_mode_o(pd), .update_o(upd), .frame_abort_o(abrt),
      .frame_drop_o(drop));
   dac_host_model i_dac_host_model (.frame_sel_b_o(sel_b),
      .sclk_o(sclk), .sdata_o(sdata));

   // 200 MHz system clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic check(input logic [21:0] got, input logic [21:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Note the expected outputs, then send; drain first unless filling
   task automatic frame(input logic [15:0] wd, input bit drain);
      logic [9:0] c;
      c = wd[9:0];
      while (drain && exp_q.size() > 0) @(negedge mclk);
      // A power-down word leaves both input registers alone
      if (wd[14:13] != dac_loader_pkg::OP_PWR_DOWN) begin
         if (wd[15]) in_b = c; else in_a = c;
      end
      case (wd[14:13])
         dac_loader_pkg::OP_WRITE_UPD: begin
            if (wd[15]) out_b = c; else out_a = c;
            pd_m = dac_loader_pkg::PD_ACTIVE;
         end
         dac_loader_pkg::OP_UPD_BOTH: begin
            out_a = in_a;
            out_b = in_b;
            pd_m = dac_loader_pkg::PD_ACTIVE;
         end
         dac_loader_pkg::OP_PWR_DOWN:
            pd_m = (wd[12:11] == 2'h0) ? dac_loader_pkg::PD_HIGH_Z
                                       : wd[12:11];
         default: ;
      endcase
      exp_q.push_back({out_a, out_b, pd_m});
      @(negedge mclk);
      i_dac_host_model.send(wd, 16);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Monitor: each applied word against the oldest note; a drop loses
   // the newest frame, whose note was pushed before it was sent
   always @(negedge mclk) begin
      if (rst_b === 1'b1 && upd === 1'b1) begin
         if (exp_q.size() == 0) begin
            error_cnt++;
            $display("wrong value at %0t: update with no word", $time);
         end else
            check({ch_a, ch_b, pd}, exp_q.pop_front());
      end
      if (drop === 1'b1 && exp_q.size() > 0) begin
         void'(exp_q.pop_back());
         drop_cnt++;
      end
      if (abrt === 1'b1) abort_cnt++;
   end

   // Watchdog sized well past the expected run
   initial begin
      #400000;
      error_cnt++;
      $display("wrong value at %0t: run timed out", $time);
      complete_run();
   end

   // Main sequence
   initial begin
      seed = 49931;
      rst_b = 1'b0;
      {in_a, in_b, out_a, out_b, pd_m} = 42'h0;
      repeat (6) @(negedge mclk);
      rst_b = 1'b1;
      // Let the pin stages settle before the first select fall
      repeat (4) @(negedge mclk);
      check({ch_a, ch_b, pd}, 22'h000000);
      // Every op code and termination, random channel and code
      for (int i = 0; i < 16; i++) begin
         w = 16'($random(seed));
         w[14:13] = i[1:0];
         w[12:11] = i[3:2];
         frame(w, 1'b1);
      end
      // Frames cut one edge in and one edge short
      @(negedge mclk);
      i_dac_host_model.send(16'($random(seed)), 1);
      @(negedge mclk);
      i_dac_host_model.send(16'($random(seed)), 15);
      // Back to back loads of A overrun the FIFO while settling
      for (int i = 0; i < 9; i++)
         frame({6'h00, 10'($random(seed))}, 1'b0);
      // Shift clock running with select high must shift nothing
      @(negedge mclk);
      i_dac_host_model.stray(8);
      frame({6'h00, 10'h3ff}, 1'b1);
      frame(16'hc000, 1'b1);
      for (int k = 0; k < 30000 && exp_q.size() > 0; k++)
         @(negedge mclk);
      repeat (20) @(negedge mclk);
      check(22'(exp_q.size()), 22'h000000);
      check(22'(abort_cnt), 22'h000002);
      check(22'(drop_cnt > 0), 22'h000001);
      complete_run();
   end
endmodule // dual_dac_serial_loader_tb_top
`default_nettype wire
